// ---- src/rcpd_pkg.sv ----
package rcpd_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PC_W   = 21;
	localparam int CFG_N  = 4;
	localparam int CFG_W  = 8;
	localparam int POWERUP_DELAY_COUNTER_W = 5;
	localparam int TICK_W = 12;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STACK_STAT = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_SEQ_STAT   = 4'h2;

	// ---------------------------------------------------------------
	// Field positions, masks and reset values
	// ---------------------------------------------------------------
	localparam int B_IPEN   = 7;
	localparam int B_CM     = 5;
	localparam int B_RI     = 4;
	localparam int B_TO     = 3;
	localparam int B_PD     = 2;
	localparam int B_POR    = 1;
	localparam int B_BOR    = 0;
	localparam int B_STACK_FULL_FLAG = 7;
	localparam int B_STACK_UNDERFLOW_FLAG = 6;

	localparam logic [DATA_W-1:0] RESET_CONTROL_REG_POR_VAL  = 8'h3C;
	localparam logic [DATA_W-1:0] RESET_CONTROL_REG_WR_MASK  = 8'hB3;
	localparam logic [DATA_W-1:0] STK_POR_VAL   = 8'h00;
	localparam logic [DATA_W-1:0] STK_WR_MASK   = 8'hC0;
	localparam logic [DATA_W-1:0] RD_UNMAPPED   = 8'h00;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RC_PERIOD_NS  = 32000;
	localparam int RC_TICK_CYC   = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [TICK_W-1:0] RC_TICK_LAST = TICK_W'(RC_TICK_CYC - 1);
	localparam logic [TICK_W-1:0] TICK_ZERO    = 12'h000;
	localparam logic [TICK_W-1:0] TICK_ONE     = 12'h001;
	localparam logic [POWERUP_DELAY_COUNTER_W-1:0] POWERUP_DELAY_COUNTER_LAST    = 5'h1F;
	localparam logic [POWERUP_DELAY_COUNTER_W-1:0] POWERUP_DELAY_COUNTER_ZERO    = 5'h00;
	localparam logic [POWERUP_DELAY_COUNTER_W-1:0] POWERUP_DELAY_COUNTER_ONE     = 5'h01;

	// ---------------------------------------------------------------
	// Program counter values
	// ---------------------------------------------------------------
	localparam logic [PC_W-1:0] VEC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] VEC_HIGH  = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW   = 21'h000018;
	localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PM_FULL  = 2'h0,
		PM_RUN   = 2'h1,
		PM_IDLE  = 2'h2,
		PM_SLEEP = 2'h3
	} rcpd_pmode_t;

	typedef enum logic [1:0] {
		ST_POWER = 2'b00,
		ST_DELAY = 2'b01,
		ST_PIN   = 2'b11,
		ST_RUN   = 2'b10
	} rcpd_state_t;

	typedef enum logic [1:0] {
		INIT_POWER = 2'h0,
		INIT_HARD  = 2'h1,
		INIT_WAKE  = 2'h2
	} rcpd_init_t;

	typedef struct packed {
		logic wdt_timeout;
		logic reset_instr;
		logic stack_full;
		logic stack_underflow;
		logic int_wake;
		logic sleep_instr;
		logic clrwdt_instr;
	} rcpd_evt_t;

endpackage

// ---- src/rcpd_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module rcpd_top (
	// Clock and reset
	input  wire logic                                      mclk,
	input  wire logic                                      srst,
	// Register port
	input  wire logic [rcpd_pkg::ADDR_W-1:0]               reg_addr,
	input  wire logic [rcpd_pkg::DATA_W-1:0]               reg_wdata,
	input  wire logic                                      reg_wr,
	input  wire logic                                      reg_rd,
	output logic      [rcpd_pkg::DATA_W-1:0]               reg_rdata,
	// Supply monitors and reset pin
	input  wire logic                                      por_pulse,
	input  wire logic                                      bor_core,
	input  wire logic                                      external_reset_pin_n,
	// Core events and state
	input  wire rcpd_pkg::rcpd_evt_t                       evt,
	input  wire rcpd_pkg::rcpd_pmode_t                     pwr_mode,
	input  wire logic                                      stack_overflow_reset_enable,
	input  wire logic                                      high_prio_global_int_enable,
	input  wire logic                                      low_prio_global_int_enable,
	input  wire logic                                      int_high_prio,
	input  wire logic      [rcpd_pkg::PC_W-1:0]            cur_pc,
	// Configuration words and their shadows
	input  wire logic [rcpd_pkg::CFG_N*rcpd_pkg::CFG_W-1:0] cfg_words,
	input  wire logic [rcpd_pkg::CFG_N*rcpd_pkg::CFG_W-1:0] cfg_shadow,
	// Sequencer outputs
	output logic                                           core_reset,
	output logic                                           pc_load,
	output logic      [rcpd_pkg::PC_W-1:0]                 pc_value,
	output logic                                           cfg_reload,
	output rcpd_pkg::rcpd_init_t                           reg_init
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic logic rcpd_is_sleepy(input rcpd_pkg::rcpd_pmode_t m);
		rcpd_is_sleepy = (m == rcpd_pkg::PM_IDLE) || (m == rcpd_pkg::PM_SLEEP);
	endfunction

	function automatic logic [rcpd_pkg::DATA_W-1:0] rcpd_wr_merge(
		input logic [rcpd_pkg::DATA_W-1:0] cur,
		input logic [rcpd_pkg::DATA_W-1:0] wd,
		input logic [rcpd_pkg::DATA_W-1:0] mask,
		input logic                        hit);
		rcpd_wr_merge = hit ? ((cur & ~mask) | (wd & mask)) : cur;
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	rcpd_pkg::rcpd_state_t             state_ff;
	rcpd_pkg::rcpd_state_t             nxt_state;
	logic [rcpd_pkg::TICK_W-1:0]       tick_cnt_ff;
	logic [rcpd_pkg::POWERUP_DELAY_COUNTER_W-1:0]       powerup_delay_counter_cnt_ff;
	logic [rcpd_pkg::DATA_W-1:0]       reset_control_reg_ff;
	logic [rcpd_pkg::DATA_W-1:0]       nxt_reset_control_reg;
	logic [rcpd_pkg::DATA_W-1:0]       stk_ff;
	logic [rcpd_pkg::DATA_W-1:0]       nxt_stk;
	logic [rcpd_pkg::DATA_W-1:0]       reg_rdata_ff;
	logic                              core_reset_ff;
	logic                              pc_load_ff;
	logic [rcpd_pkg::PC_W-1:0]         pc_value_ff;
	logic                              cfg_reload_ff;
	rcpd_pkg::rcpd_init_t              reg_init_ff;

	// ---------------------------------------------------------------
	// Event decode
	// ---------------------------------------------------------------
	wire logic power_req    = por_pulse | bor_core;
	wire logic pin_low      = ~external_reset_pin_n;
	wire logic sleepy       = rcpd_is_sleepy(pwr_mode);
	wire logic in_run       = (state_ff == rcpd_pkg::ST_RUN) & ~power_req;
	wire logic cfg_mismatch = |(~(cfg_words ^ cfg_shadow));
	wire logic take_pin     = in_run & pin_low;
	wire logic take_cm      = in_run & ~pin_low & cfg_mismatch;
	wire logic take_ri      = in_run & ~pin_low & ~cfg_mismatch & evt.reset_instr;
	wire logic rest_ok      = in_run & ~pin_low & ~cfg_mismatch & ~evt.reset_instr;
	wire logic take_wdt     = rest_ok & evt.wdt_timeout;
	wire logic wdt_reset    = take_wdt & ~sleepy;
	wire logic wdt_wake     = take_wdt & sleepy;
	wire logic stk_ok       = rest_ok & ~evt.wdt_timeout;
	wire logic take_full    = stk_ok & evt.stack_full;
	wire logic take_unf     = stk_ok & ~evt.stack_full & evt.stack_underflow;
	wire logic stk_reset    = (take_full | take_unf) & stack_overflow_reset_enable;
	wire logic take_int     = stk_ok & ~stk_reset & evt.int_wake & sleepy;
	wire logic misc_ok      = stk_ok & ~stk_reset & ~take_int;
	wire logic hard_req     = take_pin | take_cm | take_ri | wdt_reset | stk_reset;
	wire logic wake         = wdt_wake | take_int;
	wire logic gie_any      = high_prio_global_int_enable | low_prio_global_int_enable;
	wire logic rc_tick      = (tick_cnt_ff == rcpd_pkg::RC_TICK_LAST);
	wire logic powerup_delay_counter_done    = rc_tick & (powerup_delay_counter_cnt_ff == rcpd_pkg::POWERUP_DELAY_COUNTER_LAST);
	wire logic leave_power  = (state_ff == rcpd_pkg::ST_POWER) & ~power_req;
	wire logic enter_run    = (state_ff != rcpd_pkg::ST_RUN) & (nxt_state == rcpd_pkg::ST_RUN);

	wire logic [rcpd_pkg::PC_W-1:0] step_pc = rcpd_pkg::PC_W'(cur_pc + rcpd_pkg::PC_STEP);
	wire logic [rcpd_pkg::PC_W-1:0] int_vec =
		int_high_prio ? rcpd_pkg::VEC_HIGH : rcpd_pkg::VEC_LOW;
	wire logic [rcpd_pkg::PC_W-1:0] wake_pc = (take_int & gie_any) ? int_vec : step_pc;

	// ---------------------------------------------------------------
	// Register port decode
	// ---------------------------------------------------------------
	wire logic wr_reset_control_reg = reg_wr & (reg_addr == rcpd_pkg::OFS_RESET_CTRL);
	wire logic wr_stk  = reg_wr & (reg_addr == rcpd_pkg::OFS_STACK_STAT);
	wire logic [rcpd_pkg::DATA_W-1:0] sw_reset_control_reg =
		rcpd_wr_merge(reset_control_reg_ff, reg_wdata, rcpd_pkg::RESET_CONTROL_REG_WR_MASK, wr_reset_control_reg);
	wire logic [rcpd_pkg::DATA_W-1:0] sw_stk =
		rcpd_wr_merge(stk_ff, reg_wdata, rcpd_pkg::STK_WR_MASK, wr_stk);
	wire logic [rcpd_pkg::DATA_W-1:0] seq_stat = {state_ff, core_reset_ff, powerup_delay_counter_cnt_ff};
	wire logic [rcpd_pkg::DATA_W-1:0] rd_mux =
		(reg_addr == rcpd_pkg::OFS_RESET_CTRL) ? reset_control_reg_ff :
		(reg_addr == rcpd_pkg::OFS_STACK_STAT) ? stk_ff :
		(reg_addr == rcpd_pkg::OFS_SEQ_STAT)   ? seq_stat : rcpd_pkg::RD_UNMAPPED;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			rcpd_pkg::ST_POWER: begin
				if (!power_req) begin
					nxt_state = rcpd_pkg::ST_DELAY;
				end
			end
			rcpd_pkg::ST_DELAY: begin
				if (powerup_delay_counter_done) begin
					nxt_state = pin_low ? rcpd_pkg::ST_PIN : rcpd_pkg::ST_RUN;
				end
			end
			rcpd_pkg::ST_PIN: begin
				if (!pin_low) begin
					nxt_state = rcpd_pkg::ST_RUN;
				end
			end
			rcpd_pkg::ST_RUN: begin
				if (hard_req) begin
					nxt_state = rcpd_pkg::ST_PIN;
				end
			end
		endcase
		if (power_req) begin
			nxt_state = rcpd_pkg::ST_POWER;
		end
	end

	// ---------------------------------------------------------------
	// Cause flags; hardware events win over a write in the same cycle
	// ---------------------------------------------------------------
	always_comb begin
		nxt_reset_control_reg = sw_reset_control_reg;
		nxt_stk  = sw_stk;
		if (power_req) begin
			nxt_reset_control_reg[rcpd_pkg::B_IPEN] = 1'b0;
			nxt_reset_control_reg[rcpd_pkg::B_CM]   = 1'b1;
			nxt_reset_control_reg[rcpd_pkg::B_RI]   = 1'b1;
			nxt_reset_control_reg[rcpd_pkg::B_TO]   = 1'b1;
			nxt_reset_control_reg[rcpd_pkg::B_PD]   = 1'b1;
			nxt_reset_control_reg[rcpd_pkg::B_BOR]  = 1'b0;
			if (por_pulse) begin
				nxt_reset_control_reg[rcpd_pkg::B_POR] = 1'b0;
				nxt_stk                   = rcpd_pkg::STK_POR_VAL;
			end
		end else if (take_pin) begin
			nxt_reset_control_reg[rcpd_pkg::B_IPEN] = 1'b0;
			if (pwr_mode != rcpd_pkg::PM_FULL) begin
				nxt_reset_control_reg[rcpd_pkg::B_TO] = 1'b1;
			end
			if (sleepy) begin
				nxt_reset_control_reg[rcpd_pkg::B_PD] = 1'b0;
			end
		end else if (take_cm) begin
			nxt_reset_control_reg[rcpd_pkg::B_IPEN] = 1'b0;
			nxt_reset_control_reg[rcpd_pkg::B_CM]   = 1'b0;
		end else if (take_ri) begin
			nxt_reset_control_reg[rcpd_pkg::B_IPEN] = 1'b0;
			nxt_reset_control_reg[rcpd_pkg::B_RI]   = 1'b0;
		end else if (take_wdt) begin
			nxt_reset_control_reg[rcpd_pkg::B_TO] = 1'b0;
			if (sleepy) begin
				nxt_reset_control_reg[rcpd_pkg::B_PD] = 1'b0;
			end else begin
				nxt_reset_control_reg[rcpd_pkg::B_IPEN] = 1'b0;
			end
		end else begin
			if (take_full) begin
				nxt_stk[rcpd_pkg::B_STACK_FULL_FLAG] = 1'b1;
			end
			if (take_unf) begin
				nxt_stk[rcpd_pkg::B_STACK_UNDERFLOW_FLAG] = 1'b1;
			end
			if (stk_reset) begin
				nxt_reset_control_reg[rcpd_pkg::B_IPEN] = 1'b0;
			end
			if (take_int) begin
				nxt_reset_control_reg[rcpd_pkg::B_PD] = 1'b0;
			end else if (misc_ok && evt.sleep_instr) begin
				nxt_reset_control_reg[rcpd_pkg::B_TO] = 1'b1;
				nxt_reset_control_reg[rcpd_pkg::B_PD] = 1'b0;
			end else if (misc_ok && evt.clrwdt_instr) begin
				nxt_reset_control_reg[rcpd_pkg::B_TO] = 1'b1;
				nxt_reset_control_reg[rcpd_pkg::B_PD] = 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Flops
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_ff    <= rcpd_pkg::ST_POWER;
			tick_cnt_ff <= rcpd_pkg::TICK_ZERO;
			powerup_delay_counter_cnt_ff <= rcpd_pkg::POWERUP_DELAY_COUNTER_ZERO;
		end else begin
			state_ff <= nxt_state;
			if (state_ff != rcpd_pkg::ST_DELAY || power_req) begin
				tick_cnt_ff <= rcpd_pkg::TICK_ZERO;
				powerup_delay_counter_cnt_ff <= rcpd_pkg::POWERUP_DELAY_COUNTER_ZERO;
			end else if (rc_tick) begin
				tick_cnt_ff <= rcpd_pkg::TICK_ZERO;
				powerup_delay_counter_cnt_ff <= powerup_delay_counter_cnt_ff + rcpd_pkg::POWERUP_DELAY_COUNTER_ONE;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + rcpd_pkg::TICK_ONE;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			reset_control_reg_ff <= rcpd_pkg::RESET_CONTROL_REG_POR_VAL;
			stk_ff  <= rcpd_pkg::STK_POR_VAL;
		end else begin
			reset_control_reg_ff <= nxt_reset_control_reg;
			stk_ff  <= nxt_stk;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata_ff  <= rcpd_pkg::RD_UNMAPPED;
			core_reset_ff <= 1'b1;
			pc_load_ff    <= 1'b0;
			pc_value_ff   <= rcpd_pkg::VEC_RESET;
			cfg_reload_ff <= 1'b0;
			reg_init_ff   <= rcpd_pkg::INIT_POWER;
		end else begin
			reg_rdata_ff  <= reg_rd ? rd_mux : rcpd_pkg::RD_UNMAPPED;
			core_reset_ff <= (nxt_state != rcpd_pkg::ST_RUN);
			pc_load_ff    <= enter_run | wake;
			if (enter_run) begin
				pc_value_ff <= rcpd_pkg::VEC_RESET;
			end else if (wake) begin
				pc_value_ff <= wake_pc;
			end
			cfg_reload_ff <= leave_power | hard_req;
			if (power_req) begin
				reg_init_ff <= rcpd_pkg::INIT_POWER;
			end else if (hard_req) begin
				reg_init_ff <= rcpd_pkg::INIT_HARD;
			end else if (wake) begin
				reg_init_ff <= rcpd_pkg::INIT_WAKE;
			end
		end
	end

	assign reg_rdata  = reg_rdata_ff;
	assign core_reset = core_reset_ff;
	assign pc_load    = pc_load_ff;
	assign pc_value   = pc_value_ff;
	assign cfg_reload = cfg_reload_ff;
	assign reg_init   = reg_init_ff;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_quiet_run;
		(state_ff == rcpd_pkg::ST_RUN) && !power_req && !pin_low;
	endsequence

	sequence s_restart;
		core_reset_ff && (state_ff == rcpd_pkg::ST_PIN) ##1
		!core_reset_ff && pc_load_ff && (pc_value_ff == rcpd_pkg::VEC_RESET);
	endsequence

	AST_MISMATCH_RESET: assert property (
		s_quiet_run and cfg_mismatch |=> !reset_control_reg_ff[rcpd_pkg::B_CM] && cfg_reload_ff
		&& ($stable(reset_control_reg_ff[rcpd_pkg::B_RI]) && $stable(stk_ff)) ##0 s_restart)
		else $error("mismatch did not restart with cleared flag");

	AST_DELAY_HOLD: assert property (
		(state_ff == rcpd_pkg::ST_DELAY) |-> core_reset_ff)
		else $error("core released while delay counts");

	AST_DELAY_START: assert property (
		power_req |=> (state_ff == rcpd_pkg::ST_POWER) && (powerup_delay_counter_cnt_ff == rcpd_pkg::POWERUP_DELAY_COUNTER_ZERO))
		else $error("delay counted during power pulse");

	AST_DELAY_LEN: assert property (
		(state_ff == rcpd_pkg::ST_DELAY) && !power_req && !powerup_delay_counter_done
		|=> (state_ff == rcpd_pkg::ST_DELAY))
		else $error("delay ended before its full count");

	AST_PIN_RELEASE: assert property (
		(state_ff == rcpd_pkg::ST_PIN) && !pin_low && !power_req
		|=> !core_reset_ff && pc_load_ff && (pc_value_ff == rcpd_pkg::VEC_RESET))
		else $error("pin release did not start execution");

	AST_POR_FLAGS: assert property (
		por_pulse |=> (reset_control_reg_ff == rcpd_pkg::RESET_CONTROL_REG_POR_VAL) && (stk_ff == rcpd_pkg::STK_POR_VAL)
		&& (reg_init_ff == rcpd_pkg::INIT_POWER))
		else $error("power-on flags wrong");

	AST_WDT_WAKE: assert property (
		s_quiet_run and (take_wdt && sleepy)
		|=> !reset_control_reg_ff[rcpd_pkg::B_TO] && !reset_control_reg_ff[rcpd_pkg::B_PD] && !core_reset_ff
		&& pc_load_ff && (pc_value_ff == $past(cur_pc) + rcpd_pkg::PC_STEP))
		else $error("watchdog wake wrong");

	AST_UNF_NORESET: assert property (
		take_unf && !stack_overflow_reset_enable
		|=> stk_ff[rcpd_pkg::B_STACK_UNDERFLOW_FLAG] && !core_reset_ff)
		else $error("underflow without enable misbehaved");

	AST_INT_VECTOR: assert property (
		take_int && gie_any && int_high_prio |=> pc_load_ff
		&& (pc_value_ff == rcpd_pkg::VEC_HIGH) && !reset_control_reg_ff[rcpd_pkg::B_PD])
		else $error("interrupt vector not loaded");

	AST_PIN_SLEEP: assert property (
		take_pin && sleepy |=> reset_control_reg_ff[rcpd_pkg::B_TO] && !reset_control_reg_ff[rcpd_pkg::B_PD]
		&& (reg_init_ff == rcpd_pkg::INIT_HARD) && core_reset_ff)
		else $error("pin reset in sleep flags wrong");

	AST_BOR_FLAGS: assert property (
		bor_core && !por_pulse && !reg_wr |=> !reset_control_reg_ff[rcpd_pkg::B_BOR] && reset_control_reg_ff[rcpd_pkg::B_CM]
		&& reset_control_reg_ff[rcpd_pkg::B_RI] && reset_control_reg_ff[rcpd_pkg::B_TO] && reset_control_reg_ff[rcpd_pkg::B_PD]
		&& $stable(reset_control_reg_ff[rcpd_pkg::B_POR]) && $stable(stk_ff))
		else $error("brown-out flags wrong");

endmodule

`default_nettype wire

// ---- verification/rcpd_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic                     mclk, srst, reg_wr, reg_rd, por_pulse, bor_core, pin_n;
	logic                     en, gh, gl, hp, core_reset, pc_load, cfg_reload, rd_pend;
	logic                     rst_seen, reloaded;
	logic [3:0]               reg_addr;
	logic [7:0]               reg_wdata, reg_rdata, rc, stk;
	logic [20:0]              cur_pc, pc_value;
	logic [31:0]              cfg_words, cfg_shadow;
	rcpd_pkg::rcpd_evt_t      evt;
	rcpd_pkg::rcpd_pmode_t    pwr_mode;
	rcpd_pkg::rcpd_init_t     reg_init;
	logic [7:0]               rdq[$];
	logic [20:0]              pcq[$];
	int                       fails, n_tests;

	rcpd_top DUT (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_pulse(por_pulse),
		.bor_core(bor_core), .external_reset_pin_n(pin_n), .evt(evt), .pwr_mode(pwr_mode),
		.stack_overflow_reset_enable(en), .high_prio_global_int_enable(gh),
		.low_prio_global_int_enable(gl), .int_high_prio(hp), .cur_pc(cur_pc),
		.cfg_words(cfg_words), .cfg_shadow(cfg_shadow), .core_reset(core_reset),
		.pc_load(pc_load), .pc_value(pc_value), .cfg_reload(cfg_reload), .reg_init(reg_init));

	// ---------------------------------------------------------------
	// Compare and report
	// ---------------------------------------------------------------
	task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chk_pc(input string s, input logic [20:0] e, input logic [20:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chk1(input string s, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %b seen %b", s, e, g);
		end
	endtask

	task automatic chk_init(input rcpd_pkg::rcpd_init_t e, input rcpd_pkg::rcpd_init_t g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED reg_init expected %h seen %h", e, g);
		end
	endtask

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Output watcher
	// ---------------------------------------------------------------
	always @(negedge mclk) begin
		if (rd_pend)
			chk8("reg_rdata", rdq.pop_front(), reg_rdata);
		rd_pend = (reg_rd === 1'b1);
		if (pc_load === 1'b1 && pcq.size() == 0)
			chk1("pc_load", 1'b0, 1'b1);
		else if (pc_load === 1'b1)
			chk_pc("pc_value", pcq.pop_front(), pc_value);
		if (cfg_reload === 1'b1)
			reloaded = 1'b1;
		if (core_reset === 1'b1)
			rst_seen = 1'b1;
	end

	// ---------------------------------------------------------------
	// Drivers
	// ---------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		rdq.push_back(e);
		@(posedge mclk);
		reg_rd   <= 1'b0;
	endtask

	// Kinds 0..6 are event bits, 7 the reset pin, 8 a configuration mismatch
	task automatic run(input int k, input logic [1:0] m, input logic [3:0] c, input int ps,
		input logic [7:0] rcl, input logic [7:0] rst, input logic [7:0] sst);
		logic [20:0] p;
		p = 21'($urandom);
		wr(rcpd_pkg::OFS_RESET_CTRL, 8'hFF);
		wr(rcpd_pkg::OFS_STACK_STAT, 8'h00);
		rc  = (rc & 8'h4C) | 8'hB3;
		stk = 8'h00;
		@(posedge mclk);
		pwr_mode       <= rcpd_pkg::rcpd_pmode_t'(m);
		{en, gh, gl, hp} <= c;
		cur_pc         <= p;
		if (ps == 1) pcq.push_back(21'h000000);
		if (ps == 2) pcq.push_back(p + 21'h000002);
		if (ps == 3) pcq.push_back(21'h000008);
		if (ps == 4) pcq.push_back(21'h000018);
		@(posedge mclk);
		rst_seen = 1'b0;
		reloaded = 1'b0;
		if (k < 7) evt <= rcpd_pkg::rcpd_evt_t'(7'h01 << k);
		if (k == 7) pin_n <= 1'b0;
		if (k == 8) cfg_shadow <= ~cfg_words ^ 32'h00000001;
		@(posedge mclk);
		evt        <= rcpd_pkg::rcpd_evt_t'(7'h00);
		pin_n      <= 1'b1;
		cfg_shadow <= ~cfg_words;
		repeat (8) @(posedge mclk);
		rc  = (rc & ~(rcl | ((ps == 1) ? 8'h80 : 8'h00))) | rst;
		stk = stk | sst;
		rd(rcpd_pkg::OFS_RESET_CTRL, rc);
		rd(rcpd_pkg::OFS_STACK_STAT, stk);
		@(negedge mclk);
		chk1("core_reset", ps == 1, rst_seen);
		chk1("cfg_reload", ps == 1, reloaded);
		chk1("pc_load", 1'b1, pcq.size() == 0);
		if (ps == 1) chk_init(rcpd_pkg::INIT_HARD, reg_init);
		if (ps > 1) chk_init(rcpd_pkg::INIT_WAKE, reg_init);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		void'($urandom(9));
		{srst, por_pulse, pin_n} = 3'b111;
		{reg_wr, reg_rd, bor_core, en, gh, gl, hp} = 7'h00;
		reg_addr   = 4'h0;
		reg_wdata  = 8'h00;
		cur_pc     = 21'h000000;
		evt        = rcpd_pkg::rcpd_evt_t'(7'h00);
		pwr_mode   = rcpd_pkg::PM_FULL;
		cfg_words  = $urandom;
		cfg_shadow = ~cfg_words;
		fails      = 0;
		n_tests    = 0;
		rc         = 8'h3C;
		stk        = 8'h00;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		rd(rcpd_pkg::OFS_RESET_CTRL, 8'h3C);
		rd(rcpd_pkg::OFS_STACK_STAT, 8'h00);
		rd(rcpd_pkg::OFS_SEQ_STAT, 8'h20);
		repeat (20) @(posedge mclk);
		por_pulse <= 1'b0;
		pin_n     <= 1'b0;
		repeat (102300) @(posedge mclk);
		@(negedge mclk);
		chk1("core_reset", 1'b1, core_reset);
		repeat (200) @(posedge mclk);
		@(negedge mclk);
		chk1("core_reset", 1'b1, core_reset);
		pcq.push_back(21'h000000);
		@(posedge mclk);
		pin_n <= 1'b1;
		for (int i = 0; i < 4 && core_reset !== 1'b0; i++) @(negedge mclk);
		chk1("core_reset", 1'b0, core_reset);
		if (core_reset !== 1'b0) stop_test();
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		wr(rcpd_pkg::OFS_SEQ_STAT, 8'hFF);
		run(5, 2'h0, 4'h0, 1, 8'h10, 8'h00, 8'h00);
		run(7, 2'h1, 4'h0, 1, 8'h00, 8'h08, 8'h00);
		run(7, 2'h3, 4'h0, 1, 8'h04, 8'h08, 8'h00);
		run(0, 2'h0, 4'h0, 0, 8'h00, 8'h0C, 8'h00);
		run(7, 2'h2, 4'h0, 1, 8'h04, 8'h08, 8'h00);
		run(7, 2'h0, 4'h0, 1, 8'h00, 8'h00, 8'h00);
		run(6, 2'h0, 4'h0, 1, 8'h08, 8'h00, 8'h00);
		run(6, 2'h1, 4'h0, 1, 8'h08, 8'h00, 8'h00);
		run(0, 2'h0, 4'h0, 0, 8'h00, 8'h0C, 8'h00);
		run(6, 2'h2, 4'h0, 2, 8'h0C, 8'h00, 8'h00);
		run(1, 2'h0, 4'h0, 0, 8'h04, 8'h08, 8'h00);
		run(0, 2'h0, 4'h0, 0, 8'h00, 8'h0C, 8'h00);
		run(2, 2'h3, 4'h0, 2, 8'h04, 8'h00, 8'h00);
		run(0, 2'h0, 4'h0, 0, 8'h00, 8'h0C, 8'h00);
		run(2, 2'h2, 4'h5, 3, 8'h04, 8'h00, 8'h00);
		run(0, 2'h0, 4'h0, 0, 8'h00, 8'h0C, 8'h00);
		run(2, 2'h3, 4'h2, 4, 8'h04, 8'h00, 8'h00);
		run(2, 2'h0, 4'h4, 0, 8'h00, 8'h00, 8'h00);
		run(4, 2'h0, 4'h8, 1, 8'h00, 8'h00, 8'h80);
		run(3, 2'h0, 4'h8, 1, 8'h00, 8'h00, 8'h40);
		run(3, 2'h0, 4'h0, 0, 8'h00, 8'h00, 8'h40);
		run(8, 2'h0, 4'h0, 1, 8'h20, 8'h00, 8'h00);
		// Brown-out: cause flags to power values, power-on and stack flags kept
		wr(rcpd_pkg::OFS_RESET_CTRL, 8'hFF);
		wr(rcpd_pkg::OFS_STACK_STAT, 8'hC0);
		@(posedge mclk);
		bor_core <= 1'b1;
		@(posedge mclk);
		bor_core <= 1'b0;
		rd(rcpd_pkg::OFS_RESET_CTRL, 8'h3E);
		rd(rcpd_pkg::OFS_STACK_STAT, 8'hC0);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk1("core_reset", 1'b1, core_reset);
		chk_init(rcpd_pkg::INIT_POWER, reg_init);
		stop_test();
	end

endmodule

`default_nettype wire
